// >>> pst_pkg.sv
// Package: constants, types and register map of the PSI5 asynchronous frame transmitter
// Operation
// [RQ1] Every frame starts with two start bits, both zero.
// [RQ2] Manchester coding: zero is a rising sink edge, one a falling edge.
// [RQ3] Low level is quiescent current; high level switches on the extra sink.
// [RQ4] Field order: start, serial, frame control, status, B, A, check; disabled fields omitted.
// [RQ5] Serial channel adds M0 and M1 after start bits; message spans 18 frames.
// [RQ6] Serial config bit: zero gives 12-bit data and 8-bit ID, one gives 16/4.
// [RQ7] Serial CRC6, poly 1+x^3+x^4+x^6, seed 010101, over frames 7 to 18.
// [RQ8] Serial CRC augmented by six zeros; check bits sent MSB first.
// [RQ9] Frame control field follows serial bits, 1 to 4 bits long.
// [RQ10] Status field follows frame control, 1 or 2 bits long.
// [RQ11] Region B follows status, LSB first, 1 to 12 bits.
// [RQ12] Region A always present, LSB first, 10 bits up to the maximum.
// [RQ13] Each section has its own register: enable, data and length.
// [RQ14] One control bit selects even parity or a 3-bit CRC.
// [RQ15] Frame CRC poly x^3+x+1, seed 111, three zeros appended, start bits excluded.
// [RQ16] Frame CRC bits sent C2, C1, C0.
// [RQ17] Whole frame must be 13 to 33 bits long.
// [RQ18] Identification on serial bits from reset, measurement data in parallel.
// [RQ19] Meta header with code 0111 sent at least once as 10-bit value.
// [RQ20] Bit rate 125 or 189 kbps; frames repeat at a cycle time in microseconds.
// [RQ21] Serial bits placed per the enhanced 18-frame serial message layout.
// [RQ22] Receiver decodes mid-bit edges and checks frame and serial checksums; pst_rx_model only decodes, the testbench compares the check bits.
package pst_pkg;
	// ********************
	// Timing
	// ********************
	localparam int CLK_NS      = 100;
	localparam int US_NS       = 1000;
	localparam int US_CYCLES   = US_NS / CLK_NS;
	localparam int BIT_NS_LO   = 8000;
	localparam int BIT_NS_HI   = 5291;
	localparam int HALF_LO_CYC = BIT_NS_LO / 2 / CLK_NS;
	localparam int HALF_HI_CYC = BIT_NS_HI / 2 / CLK_NS;
	// ********************
	// Frame layout
	// ********************
	localparam int FRAME_MAX  = 33;
	localparam int FRAME_MIN  = 13;
	localparam int START_BITS = 2;
	localparam int SER_BITS   = 2;
	localparam int FC_MAX     = 4;
	localparam int ST_MAX     = 2;
	localparam int B_MAX      = 12;
	localparam int A_MIN      = 10;
	localparam int A_MAX      = 24;
	localparam int CRC3_W     = 3;
	localparam int PAR_W      = 1;
	localparam int SER_FRAMES = 18;
	localparam int SER_CRC_W  = 6;
	localparam int SER_WORD   = 24;
	localparam int FRM_DATA0  = 7;
	localparam int FRM_CFG    = 8;
	localparam int FRM_ID1    = 9;
	localparam int FRM_ID1_Z  = 12;
	localparam int FRM_ID2    = 14;
	localparam int FRM_ID2_Z  = 17;
	localparam logic [2:0] CRC3_POLY = 3'h3;
	localparam logic [2:0] CRC3_SEED = 3'h7;
	localparam logic [5:0] CRC6_POLY = 6'h19;
	localparam logic [5:0] CRC6_SEED = 6'h15;
	localparam logic [9:0] META_HDR  = 10'h007;
	// ********************
	// Register map
	// ********************
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_FC   = 8'h04;
	localparam logic [7:0] A_ST   = 8'h08;
	localparam logic [7:0] A_RB   = 8'h0c;
	localparam logic [7:0] A_RA   = 8'h10;
	localparam logic [7:0] A_SMSG = 8'h14;
	localparam logic [7:0] A_CYC  = 8'h18;
	localparam logic [7:0] A_STAT = 8'h1c;
	localparam int STAT_ERR = 2;
	localparam logic [15:0] CYC_RST = 16'h01f4;

	typedef logic [FRAME_MAX-1:0] pst_frame_t;
	typedef enum logic [2:0] {ST_IDLE, ST_SCRC, ST_FCRC, ST_SEND} pst_state_t;

	typedef struct packed {
		logic crc_sel;
		logic rate_hi;
		logic tx_en;
	} pst_ctrl_t;

	typedef struct packed {
		logic        en;
		logic [1:0]  rsv;
		logic [4:0]  len;
		logic [23:0] data;
	} pst_sect_t;

	typedef struct packed {
		logic        en;
		logic [5:0]  rsv;
		logic        cfg;
		logic [7:0]  id;
		logic [15:0] data;
	} pst_smsg_t;

	localparam pst_ctrl_t CTRL_RST = '{crc_sel: 1'b0, rate_hi: 1'b0, tx_en: 1'b1};
	localparam pst_sect_t SECT_RST = '0;
	localparam pst_sect_t RA_RST   = '{en: 1'b1, rsv: 2'h0, len: 5'h0a, data: 24'h000000};
	localparam pst_smsg_t SMSG_RST = '{en: 1'b1, rsv: 6'h00, cfg: 1'b0, id: 8'h00, data: 16'h0000};
endpackage : pst_pkg

// >>> pst_crc_ser.sv
// Bit-serial CRC register fed with an augmented message, MSB of the word first
`timescale 1ns/1ns
module pst_crc_ser #(
	parameter int           W    = 3,
	parameter logic [W-1:0] POLY = '0,
	parameter logic [W-1:0] SEED = '0
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         init,
	input  wire logic         shift,
	input  wire logic         din,
	output logic [W-1:0]      crc
);
	logic [W-1:0] crc_q;

	if (W < 2) begin : g_chk
		$error("CRC width too small");
	end

	// Division form: after the zero augmentation the register holds the remainder
	always_ff @(posedge clk) begin
		if (rst || init) begin
			crc_q <= SEED;
		end else if (shift) begin
			crc_q <= {crc_q[W-2:0], din} ^ (crc_q[W-1] ? POLY : '0);
		end
	end

	assign crc = crc_q;
endmodule : pst_crc_ser

// >>> pst_manchester.sv
// Manchester bit encoder driving the modulation current sink
`timescale 1ns/1ns
module pst_manchester (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic rate_hi,
	input  wire logic bit_valid,
	input  wire logic bit_val,
	output logic      bit_ready,
	output logic      busy,
	output logic      sink_on
);
	localparam logic [5:0] HALF_LO = 6'(pst_pkg::HALF_LO_CYC - 1);
	localparam logic [5:0] HALF_HI = 6'(pst_pkg::HALF_HI_CYC - 1);

	logic [5:0] cnt_q;
	logic       second_q;
	logic       act_q;
	logic       val_q;
	logic       sink_q;
	logic       half_end;
	logic [5:0] reload;

	if (pst_pkg::HALF_LO_CYC > 64 || pst_pkg::HALF_HI_CYC < 1) begin : g_chk
		$error("Half-bit count does not fit");
	end

	assign half_end  = cnt_q == '0;
	assign reload    = rate_hi ? HALF_HI : HALF_LO; // [RQ20]
	assign bit_ready = !act_q || (second_q && half_end);
	assign busy      = act_q;
	assign sink_on   = sink_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			act_q    <= 1'b0;
			second_q <= 1'b0;
			cnt_q    <= '0;
			val_q    <= 1'b0;
			sink_q   <= 1'b0;
		end else if (bit_ready) begin
			act_q    <= bit_valid;
			second_q <= 1'b0;
			cnt_q    <= reload;
			val_q    <= bit_val;
			sink_q   <= bit_valid & bit_val; // Idle stays at quiescent current [RQ3]
		end else if (half_end) begin
			second_q <= 1'b1;
			cnt_q    <= reload;
			sink_q   <= ~val_q; // Mid-bit edge: rise for zero, fall for one [RQ2]
		end else begin
			cnt_q    <= cnt_q - 6'h01;
		end
	end
endmodule : pst_manchester

// >>> pst_top.sv
// PSI5 asynchronous frame transmitter with APB register file
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ns
module pst_top #(
	parameter int INIT_HDR_FRAMES = 1,
	parameter int A_LEN_MAX       = pst_pkg::A_MAX
) (
	input  wire logic        SYS_CLK,
	input  wire logic        RST,
	input  wire logic [7:0]  PADDR,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	output logic             SINK_ON
);
	// ********************
	// Checks
	// ********************
	if (INIT_HDR_FRAMES < 1 || INIT_HDR_FRAMES > 15) begin : g_chk_hdr
		$error("Header frame count out of range");
	end
	if (A_LEN_MAX < pst_pkg::A_MIN || A_LEN_MAX > pst_pkg::A_MAX) begin : g_chk_a
		$error("Region A maximum out of range");
	end

	localparam logic [5:0] A_MAX_L = 6'(A_LEN_MAX);
	localparam logic [5:0] A_MIN_L = 6'(pst_pkg::A_MIN);
	localparam logic [5:0] SER_END = 6'(pst_pkg::SER_WORD + pst_pkg::SER_CRC_W);
	localparam logic [5:0] START_L = 6'(pst_pkg::START_BITS);
	localparam logic [3:0] HDR_N   = 4'(INIT_HDR_FRAMES);
	localparam logic [3:0] PRE_TOP = 4'(pst_pkg::US_CYCLES - 1);
	localparam logic [4:0] SER_LAST = 5'(pst_pkg::SER_FRAMES);

	// ********************
	// Registers and state
	// ********************
	pst_pkg::pst_ctrl_t  ctrl_q;
	pst_pkg::pst_sect_t  fc_q;
	pst_pkg::pst_sect_t  st_q;
	pst_pkg::pst_sect_t  rb_q;
	pst_pkg::pst_sect_t  ra_q;
	pst_pkg::pst_smsg_t  sm_q;
	pst_pkg::pst_smsg_t  msg_q;
	logic [15:0]         cyc_q;
	pst_pkg::pst_state_t state_q;
	pst_pkg::pst_frame_t v_q;
	pst_pkg::pst_frame_t v;
	logic [5:0]          cnt_q;
	logic [5:0]          pay_q;
	logic [5:0]          tot_q;
	logic [5:0]          pay;
	logic [5:0]          tot;
	logic [4:0]          ser_n_q;
	logic [3:0]          hdr_q;
	logic                err_q;
	logic                pend_q;
	logic [3:0]          pre_q;
	logic [15:0]         us_q;
	logic                len_ok;
	logic                hdr_on;
	logic                start;
	logic                frame_done;
	logic                mc_ready;
	logic                mc_busy;
	logic [2:0]          crc3;
	logic [5:0]          crc6;
	logic                f_init;
	logic                f_shift;
	logic                f_din;
	logic                s_init;
	logic                s_shift;
	logic                s_din;
	logic                sel;
	logic                wr;
	logic                mapped;
	logic [31:0]         rd;

	// ********************
	// Helpers
	// ********************
	function automatic pst_pkg::pst_frame_t lowmask(input logic [5:0] len);
		lowmask = (pst_pkg::pst_frame_t'(1) << len) - pst_pkg::pst_frame_t'(1);
	endfunction : lowmask

	// Serial bit of frame n (1..18) on M1 or M0
	function automatic logic ser_bit(input logic [4:0] n, input logic m1,
			input pst_pkg::pst_smsg_t s, input logic [5:0] c);
		int k;
		logic r;
		k = int'(n);
		r = 1'b0;
		if (m1) begin
			if (k < pst_pkg::FRM_DATA0) begin
				r = 1'b1;
			end else if (k == pst_pkg::FRM_CFG) begin
				r = s.cfg; // [RQ6]
			end else if (k >= pst_pkg::FRM_ID1 && k <= pst_pkg::FRM_ID1_Z) begin
				r = s.cfg ? s.id[3 - (k - pst_pkg::FRM_ID1)] : s.id[7 - (k - pst_pkg::FRM_ID1)]; // [RQ21]
			end else if (k >= pst_pkg::FRM_ID2 && k <= pst_pkg::FRM_ID2_Z) begin
				r = s.cfg ? s.data[15 - (k - pst_pkg::FRM_ID2)] : s.id[3 - (k - pst_pkg::FRM_ID2)]; // [RQ6]
			end
		end else begin
			if (k < pst_pkg::FRM_DATA0) begin
				r = c[pst_pkg::SER_CRC_W - k]; // Check bits C5 first [RQ8]
			end else begin
				r = s.data[11 - (k - pst_pkg::FRM_DATA0)]; // [RQ21]
			end
		end
		ser_bit = r;
	endfunction : ser_bit

	// ********************
	// Frame assembly
	// ********************
	assign hdr_on = hdr_q != '0;

	always_comb begin
		logic [5:0] alen;
		logic [23:0] adat;
		alen = hdr_on ? A_MIN_L : 6'(ra_q.len);
		adat = hdr_on ? 24'(pst_pkg::META_HDR) : ra_q.data; // Meta header at start of identification [RQ19]
		v = '0;
		pay = START_L; // Start bits stay zero [RQ1]
		if (sm_q.en) begin
			v[pay] = ser_bit(ser_n_q, 1'b0, msg_q, crc6); // [RQ5]
			v[pay + 6'h01] = ser_bit(ser_n_q, 1'b1, msg_q, crc6);
			pay = pay + 6'(pst_pkg::SER_BITS);
		end
		if (fc_q.en) begin
			v = v | ((pst_pkg::pst_frame_t'(fc_q.data) & lowmask(6'(fc_q.len))) << pay); // [RQ9]
			pay = pay + 6'(fc_q.len);
		end
		if (st_q.en) begin
			v = v | ((pst_pkg::pst_frame_t'(st_q.data) & lowmask(6'(st_q.len))) << pay); // [RQ10]
			pay = pay + 6'(st_q.len);
		end
		if (rb_q.en) begin
			v = v | ((pst_pkg::pst_frame_t'(rb_q.data) & lowmask(6'(rb_q.len))) << pay); // LSB first [RQ11]
			pay = pay + 6'(rb_q.len);
		end
		v = v | ((pst_pkg::pst_frame_t'(adat) & lowmask(alen)) << pay); // LSB first [RQ12] [RQ4]
		pay = pay + alen;
		tot = pay + (ctrl_q.crc_sel ? 6'(pst_pkg::CRC3_W) : 6'(pst_pkg::PAR_W)); // [RQ14]
	end

	// Bad lengths skip the frame rather than put a malformed one on the line
	always_comb begin
		len_ok = tot >= 6'(pst_pkg::FRAME_MIN) && tot <= 6'(pst_pkg::FRAME_MAX); // [RQ17]
		if (fc_q.en && (fc_q.len == '0 || fc_q.len > 5'(pst_pkg::FC_MAX))) begin
			len_ok = 1'b0; // [RQ9]
		end
		if (st_q.en && (st_q.len == '0 || st_q.len > 5'(pst_pkg::ST_MAX))) begin
			len_ok = 1'b0; // [RQ10]
		end
		if (rb_q.en && (rb_q.len == '0 || rb_q.len > 5'(pst_pkg::B_MAX))) begin
			len_ok = 1'b0; // [RQ11]
		end
		if (!hdr_on && (6'(ra_q.len) < A_MIN_L || 6'(ra_q.len) > A_MAX_L)) begin
			len_ok = 1'b0; // [RQ12]
		end
	end

	// ********************
	// Frame period
	// ********************
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			pre_q  <= PRE_TOP;
			us_q   <= '0;
			pend_q <= 1'b0;
		end else begin
			pre_q <= (pre_q == '0) ? PRE_TOP : pre_q - 4'h1;
			if (pre_q == '0) begin
				us_q <= (us_q >= cyc_q - 16'h0001) ? '0 : us_q + 16'h0001;
			end
			if (pre_q == '0 && cyc_q != '0 && us_q >= cyc_q - 16'h0001 && ctrl_q.tx_en) begin
				pend_q <= 1'b1; // [RQ20]
			end else if (start) begin
				pend_q <= 1'b0;
			end
		end
	end

	// ********************
	// Sequencer
	// ********************
	assign start      = state_q == pst_pkg::ST_IDLE && pend_q;
	assign frame_done = state_q == pst_pkg::ST_SEND && mc_ready && cnt_q == tot_q - 6'h01;
	assign s_init     = start && len_ok && sm_q.en && ser_n_q == 5'h01;
	assign s_shift    = state_q == pst_pkg::ST_SCRC && cnt_q < SER_END;
	assign s_din      = cnt_q < 6'(pst_pkg::SER_WORD) &&
		ser_bit(5'(pst_pkg::FRM_DATA0) + cnt_q[5:1], cnt_q[0], msg_q, crc6); // M0 of frame 7 first [RQ7]
	assign f_init     = (start && len_ok && !s_init) || (s_shift && cnt_q == SER_END - 6'h01);
	// Held while the layout is latched, or a stray zero enters the CRC
	assign f_shift    = state_q == pst_pkg::ST_FCRC && pay_q != '0 && cnt_q < pay_q + 6'(pst_pkg::CRC3_W);
	assign f_din      = cnt_q < pay_q && v_q[cnt_q]; // Zeros after data, start bits skipped [RQ15]

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			state_q <= pst_pkg::ST_IDLE;
			cnt_q   <= '0;
			v_q     <= '0;
			pay_q   <= '0;
			tot_q   <= '0;
			msg_q   <= pst_pkg::SMSG_RST;
		end else begin
			case (state_q)
				pst_pkg::ST_IDLE: begin
					if (start && s_init) begin
						msg_q   <= sm_q; // New message at frame 1 [RQ5]
						cnt_q   <= '0;
						state_q <= pst_pkg::ST_SCRC;
					end else if (start && len_ok) begin
						v_q     <= v;
						pay_q   <= pay;
						tot_q   <= tot;
						cnt_q   <= START_L;
						state_q <= pst_pkg::ST_FCRC;
					end
				end
				pst_pkg::ST_SCRC: begin
					if (cnt_q == SER_END - 6'h01) begin
						state_q <= pst_pkg::ST_FCRC;
						cnt_q   <= START_L;
					end else begin
						cnt_q <= cnt_q + 6'h01; // Six zero augmentation included [RQ8]
					end
				end
				pst_pkg::ST_FCRC: begin
					if (cnt_q == START_L && pay_q == '0) begin
						v_q   <= v; // Latched once the serial check bits are ready
						pay_q <= pay;
						tot_q <= tot;
					end else if (f_shift) begin
						cnt_q <= cnt_q + 6'h01;
					end else begin
						if (ctrl_q.crc_sel) begin
							v_q[pay_q]          <= crc3[2]; // C2, C1, C0 order [RQ16]
							v_q[pay_q + 6'h01]  <= crc3[1];
							v_q[pay_q + 6'h02]  <= crc3[0];
						end else begin
							v_q[pay_q] <= ^v_q; // Even parity [RQ14]
						end
						cnt_q   <= '0;
						state_q <= pst_pkg::ST_SEND;
					end
				end
				pst_pkg::ST_SEND: begin
					if (frame_done) begin
						state_q <= pst_pkg::ST_IDLE;
						pay_q   <= '0;
					end else if (mc_ready) begin
						cnt_q <= cnt_q + 6'h01;
					end
				end
				default: begin
					state_q <= pst_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Serial frame number and identification phase, both restart at reset [RQ18]
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			ser_n_q <= 5'h01;
			hdr_q   <= HDR_N;
		end else if (frame_done) begin
			if (hdr_on) begin
				hdr_q <= hdr_q - 4'h1; // [RQ19]
			end
			if (sm_q.en) begin
				ser_n_q <= (ser_n_q == SER_LAST) ? 5'h01 : ser_n_q + 5'h01; // Restart at frame 1 [RQ5]
			end
		end
	end

	// ********************
	// Datapath instances
	// ********************
	pst_crc_ser #(
		.W    (pst_pkg::CRC3_W),
		.POLY (pst_pkg::CRC3_POLY),
		.SEED (pst_pkg::CRC3_SEED)
	) u_crc3 (
		.clk   (SYS_CLK),
		.rst   (RST),
		.init  (f_init),
		.shift (f_shift),
		.din   (f_din),
		.crc   (crc3)
	); // [RQ15]

	pst_crc_ser #(
		.W    (pst_pkg::SER_CRC_W),
		.POLY (pst_pkg::CRC6_POLY),
		.SEED (pst_pkg::CRC6_SEED)
	) u_crc6 (
		.clk   (SYS_CLK),
		.rst   (RST),
		.init  (s_init),
		.shift (s_shift),
		.din   (s_din),
		.crc   (crc6)
	); // [RQ7]

	pst_manchester u_mc (
		.clk       (SYS_CLK),
		.rst       (RST),
		.rate_hi   (ctrl_q.rate_hi),
		.bit_valid (state_q == pst_pkg::ST_SEND),
		.bit_val   (v_q[cnt_q]),
		.bit_ready (mc_ready),
		.busy      (mc_busy),
		.sink_on   (SINK_ON)
	); // [RQ2] [RQ3]

	// ********************
	// APB slave
	// ********************
	assign sel    = PSEL && !PENABLE;
	assign wr     = PSEL && PENABLE && PWRITE && mapped;
	assign PREADY = 1'b1;
	assign mapped = PADDR[1:0] == 2'b00 && PADDR <= pst_pkg::A_STAT;

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			PSLVERR <= 1'b0;
		end else begin
			PSLVERR <= sel && !mapped;
		end
	end

	// One register per frame section [RQ13]
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			ctrl_q <= pst_pkg::CTRL_RST;
			fc_q   <= pst_pkg::SECT_RST;
			st_q   <= pst_pkg::SECT_RST;
			rb_q   <= pst_pkg::SECT_RST;
			ra_q   <= pst_pkg::RA_RST;
			sm_q   <= pst_pkg::SMSG_RST;
			cyc_q  <= pst_pkg::CYC_RST;
		end else if (wr) begin
			case (PADDR)
				pst_pkg::A_CTRL: ctrl_q <= PWDATA[2:0];
				pst_pkg::A_FC:   fc_q   <= {PWDATA[31], 2'b00, PWDATA[28:0]};
				pst_pkg::A_ST:   st_q   <= {PWDATA[31], 2'b00, PWDATA[28:0]};
				pst_pkg::A_RB:   rb_q   <= {PWDATA[31], 2'b00, PWDATA[28:0]};
				pst_pkg::A_RA:   ra_q   <= {1'b1, 2'b00, PWDATA[28:0]};
				pst_pkg::A_SMSG: sm_q   <= {PWDATA[31], 6'h00, PWDATA[24:0]};
				pst_pkg::A_CYC:  cyc_q  <= PWDATA[15:0];
				default: begin
				end
			endcase
		end
	end

	// Set wins over a same-cycle clear
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			err_q <= 1'b0;
		end else if (start && !len_ok) begin
			err_q <= 1'b1; // [RQ17]
		end else if (wr && PADDR == pst_pkg::A_STAT && PWDATA[pst_pkg::STAT_ERR]) begin
			err_q <= 1'b0;
		end
	end

	always_comb begin
		case (PADDR)
			pst_pkg::A_CTRL: rd = {29'h0, ctrl_q};
			pst_pkg::A_FC:   rd = fc_q;
			pst_pkg::A_ST:   rd = st_q;
			pst_pkg::A_RB:   rd = rb_q;
			pst_pkg::A_RA:   rd = ra_q;
			pst_pkg::A_SMSG: rd = sm_q;
			pst_pkg::A_CYC:  rd = {16'h0, cyc_q};
			pst_pkg::A_STAT: rd = {10'h0, tot, 3'h0, ser_n_q, 5'h0, err_q, hdr_on, mc_busy};
			default:         rd = '0;
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			PRDATA <= '0;
		end else if (sel) begin
			PRDATA <= rd;
		end
	end
endmodule : pst_top

// >>> pst_checker.sv
// Checker for the APB answers and the sink modulation timing of the frame transmitter
`timescale 1ns/1ns
module pst_checker (
	input wire logic        SYS_CLK,
	input wire logic        RST,
	input wire logic [7:0]  PADDR,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	input wire logic        SINK_ON
);
	// ********************
	// Helpers
	// ********************
	logic       rate_q;
	logic       last_q;
	logic [7:0] run_q;
	int         h;
	logic       acc;
	logic       bad;
	assign h   = rate_q ? pst_pkg::HALF_HI_CYC : pst_pkg::HALF_LO_CYC;
	assign acc = PSEL && PENABLE;
	assign bad = PADDR > 8'h1c || PADDR[1:0] != 2'h0;
	// Rate mirrored from writes; only changed between frames
	always_ff @(posedge SYS_CLK) begin
		if (RST)
			rate_q <= 1'b0;
		else if (acc && PWRITE && PADDR == pst_pkg::A_CTRL)
			rate_q <= PWDATA[1];
	end
	// Length of the previous level, saturating so idle reads as long
	always_ff @(posedge SYS_CLK) begin
		last_q <= RST ? 1'b0 : SINK_ON;
		if (RST)
			run_q <= 8'hff;
		else
			run_q <= (SINK_ON != last_q) ? 8'h01 : run_q + {7'h0, run_q != 8'hff};
	end
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	sequence s_idle_rise;
		!SINK_ON ##1 (SINK_ON && run_q > 8'(2 * h));
	endsequence
	sequence s_half_fall;
		$fell(SINK_ON) && run_q == 8'(h);
	endsequence
	sequence s_half_rise;
		$rose(SINK_ON) && run_q == 8'(h);
	endsequence
	AST_READY: assert property (PSEL |-> PREADY)
		else $error("pready low in a transfer");
	AST_ERR_BAD: assert property (acc && bad |-> PSLVERR)
		else $error("no error on unmapped access");
	AST_ERR_OK: assert property (acc && !bad |-> !PSLVERR)
		else $error("error on mapped access");
	AST_RD_HOLD: assert property (acc ##1 !PSEL |-> $stable(PRDATA))
		else $error("read data not held");
	AST_QUIET_RST: assert property (@(posedge SYS_CLK) disable iff (1'b0) RST |=> !SINK_ON)
		else $error("sink on after reset");
	AST_EDGE: assert property (SINK_ON != last_q |-> run_q == 8'(h) || run_q == 8'(2 * h) || (SINK_ON && run_q > 8'(2 * h)))
		else $error("sink edge off the half bit grid");
	AST_HIGH_MAX: assert property (SINK_ON && last_q |-> run_q < 8'(2 * h))
		else $error("sink on too long");
	AST_START: assert property (s_idle_rise |-> ##[1:40] s_half_fall ##[1:40] s_half_rise)
		else $error("start bits not zero");
endmodule : pst_checker
bind pst_top pst_checker u_chk (.SYS_CLK(SYS_CLK), .RST(RST), .PADDR(PADDR), .PSEL(PSEL), .PENABLE(PENABLE),
	.PWRITE(PWRITE), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SINK_ON(SINK_ON));

// >>> pst_rx_model.sv
// Receiver model that decodes the Manchester sink current into frame bits
`timescale 1ns/1ns
module pst_rx_model (
	input wire logic        clk,
	input wire logic        sink_on,
	input wire logic        rate_hi,
	output logic     [39:0] rx_bits,
	output logic     [5:0]  rx_len,
	output logic     [7:0]  rx_cnt
);
	// ********************
	// Decoder
	// ********************
	initial rx_cnt = 8'h00;
	always begin : rx_loop
		int          h;
		int          n;
		logic        v1;
		logic        v2;
		logic [39:0] b;
		@(posedge clk iff sink_on); // Mid-bit rise of the first start bit
		h  = rate_hi ? pst_pkg::HALF_HI_CYC : pst_pkg::HALF_LO_CYC;
		b  = '0;
		n  = 0;
		v1 = 1'b0;
		repeat (h / 2) @(posedge clk);
		v2 = sink_on;
		// No mid-bit transition means the frame is over
		while (v1 != v2 && n < 40) begin
			b[n] = v1;
			n++;
			repeat (h) @(posedge clk);
			v1 = sink_on;
			repeat (h) @(posedge clk);
			v2 = sink_on;
		end
		rx_bits = b;
		rx_len  = 6'(n);
		rx_cnt  = rx_cnt + 8'h01;
	end
endmodule : pst_rx_model

// >>> pst_top_test.sv
// Self-checking testbench of the frame transmitter
`timescale 1ns/1ns
module pst_top_test;
	// ********************
	// Bench
	// ********************
	logic        SYS_CLK = 1'b0;
	logic        RST = 1'b1;
	logic [7:0]  PADDR = 8'h00;
	logic        PSEL = 1'b0;
	logic        PENABLE = 1'b0;
	logic        PWRITE = 1'b0;
	logic [31:0] PWDATA = 32'h0;
	logic [31:0] PRDATA;
	logic        PREADY;
	logic        PSLVERR;
	logic        SINK_ON;
	logic [39:0] rx_bits;
	logic [5:0]  rx_len;
	logic [7:0]  rx_cnt;
	logic        rate = 1'b0;
	int          err_total = 0;
	int          n_tests = 0;
	logic [39:0] e_bits;
	int          e_len;
	logic [31:0] rd;
	logic        er;
	int          ln [4];
	logic [23:0] dt [4];
	logic        crc_on, cfg;
	logic        meta = 1'b1;
	logic [7:0]  id;
	logic [15:0] sd;
	pst_top u_dut (.SYS_CLK(SYS_CLK), .RST(RST), .PADDR(PADDR), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SINK_ON(SINK_ON));
	pst_rx_model u_rx (.clk(SYS_CLK), .sink_on(SINK_ON), .rate_hi(rate), .rx_bits(rx_bits), .rx_len(rx_len),
		.rx_cnt(rx_cnt));
	always #50 SYS_CLK = ~SYS_CLK;
	task automatic end_sim();
		if (err_total == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string m);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("Error %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		PSEL   <= 1'b1;
		PADDR  <= a;
		PWRITE <= w;
		PWDATA <= d;
		@(posedge SYS_CLK);
		PENABLE <= 1'b1;
		do
			@(posedge SYS_CLK);
		while (PREADY !== 1'b1);
		rd = PRDATA;
		er = PSLVERR;
		PSEL    <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge SYS_CLK);
	endtask : apb
	// Section index 0..3: frame control, status, region B, region A
	task automatic sect(input int i, input int l, input logic [23:0] d);
		ln[i] = l;
		dt[i] = d;
		apb(8'(pst_pkg::A_FC + 4 * i), 1'b1, {l != 0, 2'h0, 5'(l), d});
	endtask : sect
	task automatic ctrl(input logic c, input logic r);
		crc_on = c;
		rate   = r;
		apb(pst_pkg::A_CTRL, 1'b1, {29'h0, c, r, 1'b1});
	endtask : ctrl
	task automatic smsg(input logic c, input logic [7:0] i, input logic [15:0] d);
		cfg = c;
		id  = i;
		sd  = d;
		apb(pst_pkg::A_SMSG, 1'b1, {1'b1, 6'h0, c, i, d});
	endtask : smsg
	function automatic logic m_bit(input int k, input logic one, input logic [5:0] c);
		if (one) begin
			if (k <= 6) return 1'b1;
			if (k == 8) return cfg;
			if (k >= 9 && k <= 12) return cfg ? id[12 - k] : id[16 - k];
			if (k >= 14 && k <= 17) return cfg ? sd[29 - k] : id[17 - k];
			return 1'b0;
		end
		return (k <= 6) ? c[6 - k] : sd[18 - k];
	endfunction : m_bit
	function automatic logic [5:0] crc6();
		logic [5:0] c;
		logic       b;
		c = 6'b010101;
		for (int i = 0; i < 30; i++) begin
			b = (i >= 24) ? 1'b0 : m_bit(7 + i / 2, i % 2 == 1, 6'h00);
			c = {c[4:0], b} ^ (c[5] ? 6'b011001 : 6'h00);
		end
		return c;
	endfunction : crc6
	task automatic push(input logic [23:0] d, input int l);
		for (int i = 0; i < l; i++) begin
			e_bits[e_len] = d[i];
			e_len++;
		end
	endtask : push
	task automatic expect_frame(input int k);
		logic [2:0] c;
		logic [5:0] s;
		s      = crc6();
		e_bits = '0;
		e_len  = 0;
		push(24'h0, 2);
		push(24'({m_bit(k, 1'b1, s), m_bit(k, 1'b0, s)}), 2);
		for (int i = 0; i < 4; i++)
			push((i == 3 && meta) ? 24'(pst_pkg::META_HDR) : dt[i], ln[i]);
		c = 3'b111;
		for (int i = 2; i < e_len + 3; i++)
			c = {c[1:0], i < e_len ? e_bits[i] : 1'b0} ^ (c[2] ? 3'b011 : 3'h0);
		if (crc_on)
			push({21'h0, c[0], c[1], c[2]}, 3);
		else
			push(24'(^e_bits), 1);
	endtask : expect_frame
	task automatic t_frames(input int k0, input int k1);
		int w;
		for (int k = k0; k <= k1; k++) begin
			w = rx_cnt;
			wait (rx_cnt != 8'(w));
			expect_frame(k);
			chk(40'(rx_len), 40'(e_len), "frame length");
			chk(rx_bits, e_bits, "frame bits");
			meta = 1'b0;
		end
	endtask : t_frames
	task automatic t_regs();
		logic [7:0]  ad [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h20};
		logic [31:0] ev [8] = '{32'h1, 32'h0, 32'h0, 32'h0, 32'h8a000000, 32'h80000000, 32'h1f4, 32'h0};
		for (int i = 0; i < 8; i++) begin
			apb(ad[i], 1'b0, 32'h0);
			chk(40'(rd), 40'(ev[i]), "reset value");
			chk(40'(er), 40'(i == 7), "slave error");
		end
		apb(8'h10, 1'b1, 32'h0);
		apb(8'h10, 1'b0, 32'h0);
		chk(40'(rd), 40'h80000000, "region A enable");
		apb(8'h11, 1'b1, 32'hffffffff);
		chk(40'(er), 40'h1, "misaligned write");
	endtask : t_regs
	task automatic t_refuse();
		int w;
		w = rx_cnt;
		sect(0, 4, 24'ha);
		sect(2, 12, 24'h5a3);
		repeat (3500) @(posedge SYS_CLK);
		chk(40'(rx_cnt), 40'(w), "overlong frame sent");
		apb(pst_pkg::A_STAT, 1'b0, 32'h0);
		chk(40'(rd[2]), 40'h1, "length error flag");
		sect(2, 10, 24'h1a3);
		apb(pst_pkg::A_STAT, 1'b1, 32'h4);
		apb(pst_pkg::A_STAT, 1'b0, 32'h0);
		chk(40'(rd[2]), 40'h0, "length error clear");
	endtask : t_refuse
	initial begin : main
		repeat (5) @(posedge SYS_CLK);
		RST <= 1'b0;
		@(posedge SYS_CLK);
		t_regs();
		ctrl(1'b0, 1'b1);
		sect(0, 4, 24'ha);
		sect(1, 2, 24'h1);
		sect(2, 12, 24'h5a3);
		sect(3, 10, 24'h2c9);
		smsg(1'b0, 8'hc5, 16'h0b54);
		apb(pst_pkg::A_CYC, 1'b1, 32'hc8);
		t_frames(1, 9);
		// Parity to CRC costs two bits, so region B shrinks to stay at 33
		ctrl(1'b1, 1'b1);
		sect(2, 10, 24'h1a3);
		t_frames(10, 18);
		ctrl(1'b1, 1'b0);
		sect(0, 0, 24'h0);
		smsg(1'b1, 8'h3e, 16'hd6b2);
		apb(pst_pkg::A_CYC, 1'b1, 32'h12c);
		t_frames(1, 12);
		t_refuse();
		end_sim();
	end
	initial begin : watchdog
		repeat (100000) @(posedge SYS_CLK);
		err_total++;
		end_sim();
	end
endmodule : pst_top_test
